// file: bench/host_model.sv
/*
 * Host side of the three-wire programming link: shifts 24-bit words.
 * Assumes a free-running ref_clk; serial clock is 8 ref_clk cycles long.
 */
`default_nettype none

module host_model (
	// Timing reference
	input wire logic ref_clk,
	// Serial pins
	output logic serial_clk,
	output logic serial_data,
	output logic latch_strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	// Link idles with clock low; no free-running clock between words
	initial
	begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b0;
	end

	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--)
		begin
			serial_data <= w[i];
			repeat (4) @(posedge ref_clk);
			serial_clk <= 1'b1;
			repeat (4) @(posedge ref_clk);
			serial_clk <= 1'b0;
		end
		// Data is stale now, so show its inverse rather than hold it
		serial_data <= ~w[0];
		latch_strobe <= 1'b1;
		repeat (4) @(posedge ref_clk);
		latch_strobe <= 1'b0;
	endtask : send
endmodule : host_model

`default_nettype wire

// file: bench/synth_serial_control_port_asserts.sv
/*
 * Port checker for the synthesizer serial control port.
 * Assumes it is bound to the top module and sees its ports only.
 */
`default_nettype none

module synth_port_checker #(
	parameter bit HIGH_BAND = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Watched pins
	input wire logic latch_strobe,
	input wire logic chip_enable,
	input wire logic osc_buffer_enable,
	input wire logic rf_powered,
	input wire logic if_powered,
	input wire logic osc_buffer_powered,
	input wire logic rf_pump_oe,
	input wire logic if_pump_oe,
	input wire synth_pkg::modulus_t rf_modulus,
	input wire synth_pkg::modulus_t if_modulus,
	input wire logic [21:0] rf_n_word,
	input wire logic [21:0] if_r_word,
	input wire logic osc_or_if_speedup_out_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// Cycles since the latch pin rose, saturating
	logic lat_q;
	logic [3:0] age_q;
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			lat_q <= 1'b0;
			age_q <= 4'hF;
		end
		else
		begin
			lat_q <= latch_strobe;
			age_q <= (latch_strobe && !lat_q) ? 4'h0 :
				(age_q == 4'hF ? age_q : age_q + 4'h1);
		end
	end

	// Five samples: the synchroniser refills from zero after reset
	sequence osc_held;
		osc_buffer_enable [*5];
	endsequence

	pump_float_a: assert property (
		!chip_enable |-> !rf_pump_oe && !if_pump_oe)
		else $error("pump driven while chip disabled");
	power_off_a: assert property (
		!chip_enable |-> !rf_powered && !if_powered)
		else $error("synth powered while chip disabled");
	power_needs_en_a: assert property (
		(rf_powered || if_powered) |-> chip_enable)
		else $error("synth powered without chip enable");
	osc_keep_a: assert property (
		osc_held |-> osc_buffer_powered)
		else $error("oscillator buffer dropped");
	osc_pin_a: assert property (
		osc_held |-> osc_or_if_speedup_out_oe)
		else $error("oscillator pin not driven");
	rf_n_load_a: assert property (
		$changed(rf_n_word) |-> age_q inside {[1:5]})
		else $error("rf_n_word changed without latch");
	if_r_load_a: assert property (
		$changed(if_r_word) |-> age_q inside {[1:5]})
		else $error("if_r_word changed without latch");
	rf_band_a: assert property (
		HIGH_BAND || rf_modulus != synth_pkg::MOD_32_33)
		else $error("rf ratio not offered on this band");
	if_band_a: assert property (
		if_modulus != synth_pkg::MOD_32_33)
		else $error("if ratio out of range");
endmodule : synth_port_checker

bind synth_serial_control_port synth_port_checker #(.HIGH_BAND(HIGH_BAND)) chk_u (
	.ref_clk(ref_clk), .rstn(rstn), .latch_strobe(latch_strobe),
	.chip_enable(chip_enable), .osc_buffer_enable(osc_buffer_enable),
	.rf_powered(rf_powered), .if_powered(if_powered),
	.osc_buffer_powered(osc_buffer_powered), .rf_pump_oe(rf_pump_oe),
	.if_pump_oe(if_pump_oe), .rf_modulus(rf_modulus),
	.if_modulus(if_modulus), .rf_n_word(rf_n_word), .if_r_word(if_r_word),
	.osc_or_if_speedup_out_oe(osc_or_if_speedup_out_oe));

`default_nettype wire

// file: bench/tb.sv
/*
 * Self-checking bench: words sent through the host model, pins compared.
 * Assumes the port is built with HIGH_BAND 0 and the default SPAN_W.
 */
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk, rstn, chip_enable, osc_buffer_enable, reference_in;
	logic rf_divider_tap, if_divider_tap, rf_lock_raw, if_lock_raw;
	wire logic serial_clk, serial_data, latch_strobe;
	logic rf_powered, if_powered, osc_buffer_powered, rf_pump_oe, if_pump_oe;
	logic rf_pump_high_current, if_pump_high_current;
	synth_pkg::modulus_t rf_modulus, if_modulus;
	logic [21:0] rf_n_word, if_n_word, rf_r_word, if_r_word, ext_w;
	logic rf_speedup_out, rf_speedup_out_oe, osc_or_if_speedup_out;
	logic osc_or_if_speedup_out_oe, test_lock_mux_out, test_lock_mux_out_oe;
	int n_errors = 0;
	int checked = 0;

	host_model host_u (.ref_clk(ref_clk), .serial_clk(serial_clk),
		.serial_data(serial_data), .latch_strobe(latch_strobe));

	synth_serial_control_port #(.HIGH_BAND(1'b0)) dut_u (
		.ref_clk(ref_clk), .rstn(rstn), .serial_clk(serial_clk),
		.serial_data(serial_data), .latch_strobe(latch_strobe),
		.chip_enable(chip_enable), .osc_buffer_enable(osc_buffer_enable),
		.reference_in(reference_in), .rf_divider_tap(rf_divider_tap),
		.if_divider_tap(if_divider_tap), .rf_lock_raw(rf_lock_raw),
		.if_lock_raw(if_lock_raw),
		.rf_powered(rf_powered), .if_powered(if_powered),
		.osc_buffer_powered(osc_buffer_powered), .rf_pump_oe(rf_pump_oe),
		.if_pump_oe(if_pump_oe), .rf_pump_high_current(rf_pump_high_current),
		.if_pump_high_current(if_pump_high_current),
		.rf_modulus(rf_modulus), .if_modulus(if_modulus),
		.rf_n_word(rf_n_word), .if_n_word(if_n_word), .rf_r_word(rf_r_word),
		.if_r_word(if_r_word), .rf_speedup_out(rf_speedup_out),
		.rf_speedup_out_oe(rf_speedup_out_oe),
		.osc_or_if_speedup_out(osc_or_if_speedup_out),
		.osc_or_if_speedup_out_oe(osc_or_if_speedup_out_oe),
		.test_lock_mux_out(test_lock_mux_out),
		.test_lock_mux_out_oe(test_lock_mux_out_oe));

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Settle one ns past the edge so registered outputs have landed
	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_n

	task automatic put(input logic [23:0] w);
		@(posedge ref_clk);
		host_u.send(w);
		wait_n(8);
	endtask : put

	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask : end_test

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		test_done;
	end

	initial
	begin
		rstn = 1'b0;
		chip_enable = 1'b1;
		osc_buffer_enable = 1'b1;
		reference_in = 1'b1;
		rf_divider_tap = 1'b1;
		if_divider_tap = 1'b0;
		rf_lock_raw = 1'b1;
		if_lock_raw = 1'b1;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		// RF: 16/17, 4 mA, time-out span 2 units
		put(24'h000218);
		`CHK("rf_modulus", synth_pkg::MOD_16_17, rf_modulus)
		`CHK("rf_cur", 1'b1, rf_pump_high_current)
		`CHK("rf_powered", 1'b1, rf_powered)
		`CHK("rf_pump_oe", 1'b1, rf_pump_oe)
		// IF: 8/9, 1 mA, gpo low, test pin as gpo high
		put(24'h080021);
		`CHK("if_modulus", synth_pkg::MOD_8_9, if_modulus)
		`CHK("if_cur", 1'b0, if_pump_high_current)
		`CHK("test_out", 1'b1, test_lock_mux_out)
		`CHK("test_oe", 1'b1, test_lock_mux_out_oe)
		`CHK("osc_out", 1'b1, osc_or_if_speedup_out)
		`CHK("if_pump_oe", 1'b1, if_pump_oe)
		end_test("config");
		put({22'h15A5A5, 2'h2});
		`CHK("rf_n", 22'h15A5A5, rf_n_word)
		`CHK("fl_oe", 1'b1, rf_speedup_out_oe)
		`CHK("fl_out", 1'b0, rf_speedup_out)
		wait_n(20);
		`CHK("fl_oe_mid", 1'b1, rf_speedup_out_oe)
		wait_n(20);
		`CHK("fl_oe_end", 1'b0, rf_speedup_out_oe)
		end_test("fastlock");
		for (int i = 0; i < 3; i++)
		begin
			put({20'hC3A50 + 20'(i), 2'(i), 2'h3});
			ext_w = i == 0 ? if_n_word : (i == 1 ? rf_r_word : if_r_word);
			`CHK("ext_word", {20'hC3A50 + 20'(i), 2'(i)}, ext_w)
		end
		put({20'hFFFFF, 2'h3, 2'h3});
		`CHK("if_r_kept", {20'hC3A52, 2'h2}, if_r_word)
		end_test("select");
		// RF powered down by its own bit, fastlock pin as gpo high
		put(24'h000064);
		`CHK("rf_gpo", 1'b1, rf_speedup_out)
		`CHK("rf_gpo_oe", 1'b1, rf_speedup_out_oe)
		`CHK("rf_pd", 1'b0, rf_powered)
		`CHK("if_up", 1'b1, if_powered)
		@(posedge ref_clk) osc_buffer_enable <= 1'b0;
		wait_n(6);
		`CHK("if_fl_out", 1'b0, osc_or_if_speedup_out)
		`CHK("if_fl_oe", 1'b1, osc_or_if_speedup_out_oe)
		@(posedge ref_clk) chip_enable <= 1'b0;
		wait_n(6);
		`CHK("if_pump_oe", 1'b0, if_pump_oe)
		`CHK("if_off", 1'b0, if_powered)
		`CHK("osc_off", 1'b0, osc_buffer_powered)
		@(posedge ref_clk) osc_buffer_enable <= 1'b1;
		wait_n(6);
		`CHK("osc_kept", 1'b1, osc_buffer_powered)
		@(posedge ref_clk) chip_enable <= 1'b1;
		wait_n(6);
		`CHK("if_back", 1'b1, if_powered)
		end_test("enables");
		// Test pin: rf divider tap, filtered lock, rf open-drain lock
		put(24'h010001);
		`CHK("tm_rf_div", 1'b1, test_lock_mux_out)
		put(24'h070001);
		`CHK("tm_dig_ld", 1'b1, test_lock_mux_out)
		@(posedge ref_clk) if_lock_raw <= 1'b0;
		wait_n(6);
		`CHK("tm_dig_drop", 1'b0, test_lock_mux_out)
		@(posedge ref_clk) if_lock_raw <= 1'b1;
		wait_n(20);
		`CHK("tm_dig_wait", 1'b0, test_lock_mux_out)
		wait_n(20);
		`CHK("tm_dig_lock", 1'b1, test_lock_mux_out)
		put(24'h050001);
		`CHK("tm_od_off", 1'b0, test_lock_mux_out_oe)
		@(posedge ref_clk) rf_lock_raw <= 1'b0;
		wait_n(6);
		`CHK("tm_od_low", 1'b1, test_lock_mux_out_oe)
		`CHK("tm_od_out", 1'b0, test_lock_mux_out)
		end_test("test_pin");
		test_done;
	end
endmodule : tb

`default_nettype wire

// file: shared/synth_consts.svh
/*
 * Constants of the synthesizer serial control port: word layout, register
 * indices, field positions, reset values and timing counts.
 * Assumes it is included by bare name after the package is compiled.
 */
`ifndef SYNTH_CONSTS_SVH
`define SYNTH_CONSTS_SVH

// ----------------------------------------------------------------------
// Serial word
// ----------------------------------------------------------------------
`define CTL_W 24
`define ADDR_MSB 1
`define ADDR_LSB 0
`define SUB_MSB 3
`define SUB_LSB 2
`define ADDR_EXT 2'h3
`define SUB_NONE 2'h3
`define CTL_RESET 24'h000000
`define NUM_CTL 6

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define IDX_RF_CFG 3'h0
`define IDX_IF_CFG 3'h1
`define IDX_RF_N 3'h2
`define IDX_IF_N 3'h3
`define IDX_RF_R 3'h4
`define IDX_IF_R 3'h5

// ----------------------------------------------------------------------
// Fields of both config registers (the MUX fields of the IF one only), and the word field of the divider registers
// ----------------------------------------------------------------------
`define PD_BIT 2
`define PRE_BIT 3
`define CUR_BIT 4
`define GPO_MODE_BIT 5
`define GPO_VAL_BIT 6
`define SPAN_LSB 8
`define SPAN_MSB 15
`define MUX_LSB 16
`define MUX_MSB 18
`define MUX_GPO_BIT 19
`define WORD_LSB 2
`define WORD_MSB 23

// ----------------------------------------------------------------------
// Timing counts, in ref_clk cycles
// ----------------------------------------------------------------------
`define SPEEDUP_UNIT_SHIFT 4
`define LOCK_FILTER_CYCLES 8'h20

`endif

// file: shared/synth_pkg.sv
/*
 * Types of the synthesizer serial control port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package synth_pkg;

	// Dual-modulus prescaler ratio in use
	typedef enum logic [1:0] {
		MOD_8_9 = 2'h0,
		MOD_16_17 = 2'h1,
		MOD_32_33 = 2'h2
	} modulus_t;

	// Source of the test and lock pin
	typedef enum logic [2:0] {
		TM_GPO = 3'h0,
		TM_RF_DIV = 3'h1,
		TM_IF_DIV = 3'h2,
		TM_RF_LD_PP = 3'h3,
		TM_IF_LD_PP = 3'h4,
		TM_RF_LD_OD = 3'h5,
		TM_IF_LD_OD = 3'h6,
		TM_DIG_LD = 3'h7
	} test_sel_t;

	// Speedup timer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_RUN = 2'h2
	} timer_state_t;

endpackage : synth_pkg

`default_nettype wire

// file: verilog/pin_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is an unrelated level from outside the clock domain.
 */
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : pin_sync

`default_nettype wire

// file: verilog/speedup_timer.sv
/*
 * Fastlock time-out counter: holds active for span units after start.
 * Assumes start is a one-cycle pulse on clk; span of zero never starts.
 */
`default_nettype none
`include "synth_consts.svh"

module speedup_timer #(
	parameter int SPAN_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control
	input wire logic start,
	input wire logic [SPAN_W-1:0] span,
	output logic active
);

	localparam int CW = SPAN_W + `SPEEDUP_UNIT_SHIFT;

	synth_pkg::timer_state_t state_q;
	synth_pkg::timer_state_t state_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	wire go = start && (span != '0);
	wire [CW-1:0] load = {span, {`SPEEDUP_UNIT_SHIFT{1'b0}}};

	// A restart while running reloads the full span
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			synth_pkg::ST_IDLE:
				if (go)
				begin
					state_d = synth_pkg::ST_RUN;
					cnt_d = load;
				end
			synth_pkg::ST_RUN:
				if (go)
					cnt_d = load;
				else if (cnt_q == CW'(1))
				begin
					state_d = synth_pkg::ST_IDLE;
					cnt_d = '0;
				end
				else
					cnt_d = cnt_q - CW'(1);
			default:
			begin
				state_d = synth_pkg::ST_IDLE;
				cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= synth_pkg::ST_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	assign active = (state_q == synth_pkg::ST_RUN);

endmodule : speedup_timer

`default_nettype wire

// file: verilog/synth_serial_control_port.sv
/*
 * Serial programming port with power, prescaler, pump current, fastlock
 * and test pin control for a dual RF/IF synthesizer.
 * Assumes all pin inputs are asynchronous to ref_clk and that the serial
 * clock is much slower than ref_clk (at least four cycles per phase).
 */
`default_nettype none
`include "synth_consts.svh"

module synth_serial_control_port #(
	parameter bit HIGH_BAND = 1'b0,
	parameter int SPAN_W = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Serial programming pins
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic latch_strobe,
	// Enable pins
	input wire logic chip_enable,
	input wire logic osc_buffer_enable,
	// Analog side levels
	input wire logic reference_in,
	input wire logic rf_divider_tap,
	input wire logic if_divider_tap,
	input wire logic rf_lock_raw,
	input wire logic if_lock_raw,
	// Synthesizer controls
	output logic rf_powered,
	output logic if_powered,
	output logic osc_buffer_powered,
	output logic rf_pump_oe,
	output logic if_pump_oe,
	output logic rf_pump_high_current,
	output logic if_pump_high_current,
	output synth_pkg::modulus_t rf_modulus,
	output synth_pkg::modulus_t if_modulus,
	// Divider words
	output logic [21:0] rf_n_word,
	output logic [21:0] if_n_word,
	output logic [21:0] rf_r_word,
	output logic [21:0] if_r_word,
	// Output pins
	output logic rf_speedup_out,
	output logic rf_speedup_out_oe,
	output logic osc_or_if_speedup_out,
	output logic osc_or_if_speedup_out_oe,
	output logic test_lock_mux_out,
	output logic test_lock_mux_out_oe
);

	if (SPAN_W < 1 || SPAN_W > 8)
		$error("SPAN_W must lie between 1 and 8");

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [9:0] pins_s;

	pin_sync #(
		.WIDTH(10)
	) u_pin_sync (
		.clk(ref_clk),
		.rstn(rstn),
		.d({serial_clk, serial_data, latch_strobe, chip_enable,
			osc_buffer_enable, reference_in, rf_divider_tap,
			if_divider_tap, rf_lock_raw, if_lock_raw}),
		.q(pins_s)
	);

	wire sclk_s = pins_s[9];
	wire data_s = pins_s[8];
	wire latch_s = pins_s[7];
	wire en_s = pins_s[6];
	wire osc_en_s = pins_s[5];
	wire ref_s = pins_s[4];
	wire rf_div_s = pins_s[3];
	wire if_div_s = pins_s[2];
	wire rf_lock_s = pins_s[1];
	wire if_lock_s = pins_s[0];

	// ------------------------------------------------------------------
	// Serial shift and latch
	// ------------------------------------------------------------------
	logic sclk_prev_q;
	logic latch_prev_q;
	logic [`CTL_W-1:0] shift_q;
	logic [`CTL_W-1:0] ctrl_q [`NUM_CTL];

	// Clock and data share the same sync delay, so data is aligned
	wire sclk_rise = sclk_s & ~sclk_prev_q;
	wire latch_rise = latch_s & ~latch_prev_q;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclk_prev_q <= 1'b0;
			latch_prev_q <= 1'b0;
			shift_q <= `CTL_RESET;
		end
		else
		begin
			sclk_prev_q <= sclk_s;
			latch_prev_q <= latch_s;
			if (sclk_rise)
				shift_q <= {shift_q[`CTL_W-2:0], data_s};
		end
	end

	wire [1:0] addr = shift_q[`ADDR_MSB:`ADDR_LSB];
	wire [1:0] sub = shift_q[`SUB_MSB:`SUB_LSB];
	wire ext = (addr == `ADDR_EXT);
	// Extended address adds three more registers behind code 3
	wire [2:0] idx = ext ? 3'(`IDX_IF_N + {1'b0, sub}) : {1'b0, addr};
	wire idx_ok = !(ext && sub == `SUB_NONE);
	wire load = latch_rise && idx_ok;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < `NUM_CTL; i++)
				ctrl_q[i] <= `CTL_RESET;
		end
		else if (load)
			ctrl_q[idx] <= shift_q;
	end

	wire [`CTL_W-1:0] rf_cfg = ctrl_q[`IDX_RF_CFG];
	wire [`CTL_W-1:0] if_cfg = ctrl_q[`IDX_IF_CFG];

	assign rf_n_word = ctrl_q[`IDX_RF_N][`WORD_MSB:`WORD_LSB];
	assign if_n_word = ctrl_q[`IDX_IF_N][`WORD_MSB:`WORD_LSB];
	assign rf_r_word = ctrl_q[`IDX_RF_R][`WORD_MSB:`WORD_LSB];
	assign if_r_word = ctrl_q[`IDX_IF_R][`WORD_MSB:`WORD_LSB];

	// ------------------------------------------------------------------
	// Power control
	// ------------------------------------------------------------------
	// Raw pin clears asynchronously; no clock needed to shut down
	wire pd_rstn = rstn & chip_enable;
	wire rf_on_d = en_s & ~rf_cfg[`PD_BIT];
	wire if_on_d = en_s & ~if_cfg[`PD_BIT];

	always_ff @(posedge ref_clk or negedge pd_rstn)
	begin
		if (!pd_rstn)
		begin
			rf_powered <= 1'b0;
			if_powered <= 1'b0;
			rf_pump_oe <= 1'b0;
			if_pump_oe <= 1'b0;
		end
		else
		begin
			rf_powered <= rf_on_d;
			if_powered <= if_on_d;
			rf_pump_oe <= rf_on_d;
			if_pump_oe <= if_on_d;
		end
	end

	// ------------------------------------------------------------------
	// Prescaler and pump current
	// ------------------------------------------------------------------
	wire rf_pre = rf_cfg[`PRE_BIT];
	wire synth_pkg::modulus_t rf_mod_hi =
		rf_pre ? synth_pkg::MOD_32_33 : synth_pkg::MOD_16_17;
	wire synth_pkg::modulus_t rf_mod_lo =
		rf_pre ? synth_pkg::MOD_16_17 : synth_pkg::MOD_8_9;
	wire synth_pkg::modulus_t rf_mod_d =
		HIGH_BAND ? rf_mod_hi : rf_mod_lo;
	wire synth_pkg::modulus_t if_mod_d = if_cfg[`PRE_BIT] ?
		synth_pkg::MOD_16_17 : synth_pkg::MOD_8_9;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rf_modulus <= synth_pkg::MOD_8_9;
			if_modulus <= synth_pkg::MOD_8_9;
			rf_pump_high_current <= 1'b0;
			if_pump_high_current <= 1'b0;
		end
		else
		begin
			rf_modulus <= rf_mod_d;
			if_modulus <= if_mod_d;
			rf_pump_high_current <= rf_cfg[`CUR_BIT];
			if_pump_high_current <= if_cfg[`CUR_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Fastlock timers
	// ------------------------------------------------------------------
	logic rf_fast;
	logic if_fast;

	// A frequency word write or a power-up each start the timer
	wire rf_start = (load && idx == `IDX_RF_N) ||
		(rf_on_d && !rf_powered);
	wire if_start = (load && idx == `IDX_IF_N) ||
		(if_on_d && !if_powered);

	speedup_timer #(
		.SPAN_W(SPAN_W)
	) u_rf_timer (
		.clk(ref_clk),
		.rstn(rstn),
		.start(rf_start),
		.span(rf_cfg[`SPAN_LSB +: SPAN_W]),
		.active(rf_fast)
	);

	speedup_timer #(
		.SPAN_W(SPAN_W)
	) u_if_timer (
		.clk(ref_clk),
		.rstn(rstn),
		.start(if_start),
		.span(if_cfg[`SPAN_LSB +: SPAN_W]),
		.active(if_fast)
	);

	// ------------------------------------------------------------------
	// Speedup and oscillator pins
	// ------------------------------------------------------------------
	// Fastlock pulls low to switch the resistor in; GPO mode drives its value, else floats
	wire rf_gpo = rf_cfg[`GPO_MODE_BIT];
	wire rf_sp_out_d = rf_gpo & rf_cfg[`GPO_VAL_BIT];
	wire rf_sp_oe_d = rf_gpo | rf_fast;
	wire if_gpo = if_cfg[`GPO_MODE_BIT];
	wire if_sp_out_d = if_gpo & if_cfg[`GPO_VAL_BIT];
	wire if_sp_oe_d = if_gpo | if_fast;
	wire osc_pwr_d = osc_en_s | en_s;
	wire osc_out_d = osc_en_s ? ref_s : if_sp_out_d;
	wire osc_oe_d = osc_en_s ? osc_pwr_d : if_sp_oe_d;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rf_speedup_out <= 1'b0;
			rf_speedup_out_oe <= 1'b0;
			osc_or_if_speedup_out <= 1'b0;
			osc_or_if_speedup_out_oe <= 1'b0;
			osc_buffer_powered <= 1'b0;
		end
		else
		begin
			rf_speedup_out <= rf_sp_out_d;
			rf_speedup_out_oe <= rf_sp_oe_d;
			osc_or_if_speedup_out <= osc_out_d;
			osc_or_if_speedup_out_oe <= osc_oe_d;
			osc_buffer_powered <= osc_pwr_d;
		end
	end

	// ------------------------------------------------------------------
	// Lock filter and test pin
	// ------------------------------------------------------------------
	logic [7:0] lock_cnt_q;

	// Any unlock sample restarts the count; glitches never pass
	wire both_lock = rf_lock_s & if_lock_s;
	wire dig_lock = (lock_cnt_q == `LOCK_FILTER_CYCLES);

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			lock_cnt_q <= 8'h00;
		else if (!both_lock)
			lock_cnt_q <= 8'h00;
		else if (!dig_lock)
			lock_cnt_q <= lock_cnt_q + 8'h01;
	end

	wire synth_pkg::test_sel_t tsel =
		synth_pkg::test_sel_t'(if_cfg[`MUX_MSB:`MUX_LSB]);
	logic tm_out_d;
	logic tm_oe_d;

	always_comb
	begin
		tm_out_d = 1'b0;
		tm_oe_d = 1'b1;
		unique case (tsel)
			synth_pkg::TM_GPO:
				tm_out_d = if_cfg[`MUX_GPO_BIT];
			synth_pkg::TM_RF_DIV:
				tm_out_d = rf_div_s;
			synth_pkg::TM_IF_DIV:
				tm_out_d = if_div_s;
			synth_pkg::TM_RF_LD_PP:
				tm_out_d = rf_lock_s;
			synth_pkg::TM_IF_LD_PP:
				tm_out_d = if_lock_s;
			synth_pkg::TM_RF_LD_OD:
				tm_oe_d = ~rf_lock_s;
			synth_pkg::TM_IF_LD_OD:
				tm_oe_d = ~if_lock_s;
			synth_pkg::TM_DIG_LD:
				tm_out_d = dig_lock;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			test_lock_mux_out <= 1'b0;
			test_lock_mux_out_oe <= 1'b0;
		end
		else
		begin
			test_lock_mux_out <= tm_out_d;
			test_lock_mux_out_oe <= tm_oe_d;
		end
	end

endmodule : synth_serial_control_port

`default_nettype wire
